// *** rtl/aps_cfg.svh ***
// Purpose: constants for the absolute position serial report, both ends
// Assumes: one 20 MHz clock at each end
// Notes: times kept in their own units, cycle counts derived from them
// Overview of operation
// [R1] upper 16 signed bits sent serially on phase A
// [R2] lower 20 bits sent as a pulse train
// [R3] 9600 baud, start, 7 data, even parity, stop
// [R4] message sent only once after power-up
// [R5] eight chars: P, sign, five digits, CR
// [R6] signed 36-bit position split 16 upper, 20 lower
// [R7] position divided by divider setting before split
// [R8] host position is upper*1048576 plus lower, minus origin
// [R9] host captures origin value once and keeps it
// [R10] reverse direction uses the same host arithmetic
// [R11] afterwards quadrature increments, origin pulse always passed
// [R12] host counts no pulses during serial message
// [R13] data LSB first, line idles high
// [R14] digits ASCII, MSB first, sign plus or minus
`ifndef APS_CFG_SVH
`define APS_CFG_SVH
`define APS_CLK_HZ 20000000
`define APS_BAUD 9600
`define APS_BIT_CYC (`APS_CLK_HZ / `APS_BAUD)
`define APS_EDGE_NS 500
`define APS_EDGE_CYC ((`APS_EDGE_NS * (`APS_CLK_HZ / 1000000) + 999) / 1000)
`define APS_GAP_US 1000
`define APS_GAP_CYC (`APS_GAP_US * (`APS_CLK_HZ / 1000000))
`define APS_IDLE_US 500
`define APS_IDLE_CYC (`APS_IDLE_US * (`APS_CLK_HZ / 1000000))
`define APS_POS_W 36
`define APS_UP_W 16
`define APS_LOW_W 20
`define APS_DIV_W 16
`define APS_FRAME_BITS 10
`define APS_MSG_CHARS 8
`define APS_DIGITS 5
`define APS_CH_P 7'h50
`define APS_CH_PLUS 7'h2B
`define APS_CH_MINUS 7'h2D
`define APS_CH_ZERO 7'h30
`define APS_CH_CR 7'h0D
`endif

// *** rtl/aps_pkg.sv ***
// Purpose: state types shared by both ends
// Assumes: aps_cfg.svh on the include path
// Notes: each module keeps its state in one struct, apart from the registered report_done flag in aps_dev
`default_nettype none
`include "aps_cfg.svh"
package aps_pkg;
  // device sequence from power-up to incremental running
  typedef enum logic [3:0] {D_WAIT, D_DIV, D_SIGN, D_BCD, D_CHR, D_BIT, D_GAP, D_TRAIN,
    D_SETTLE, D_INC} aps_dst_e;
  // host receive and count phases
  typedef enum logic [1:0] {H_HUNT, H_BITS, H_COUNT} aps_hst_e;
  typedef struct packed {
    aps_dst_e st;
    logic [15:0] tmr; // bit, gap and edge timer
    logic [3:0] bitn; // bit within frame
    logic [2:0] chr; // char within message
    logic [9:0] shf; // frame shifter
    logic neg; // sign of undivided value
    logic sgn; // sign of upper part
    logic [15:0] dv; // latched divisor
    logic [35:0] num; // dividend shifting out
    logic [35:0] quo; // quotient, then signed result
    logic [16:0] rem; // partial remainder
    logic [5:0] itr; // divide step
    logic [15:0] val; // magnitude under digit conversion
    logic [2:0] di; // digit being found
    logic [4:0][3:0] dig; // decimal digits, [0] most significant
    logic [19:0] low; // edges still to send
    logic [1:0] ph; // quadrature phase
    logic a; // phase A pin
    logic b; // phase B pin
    logic z; // origin pin
  } aps_dev_s;
  typedef struct packed {
    aps_hst_e st;
    logic [2:0] s1; // first sync stage
    logic [2:0] s2; // second sync stage
    logic [1:0] prv; // previous synced A,B
    logic zprv; // previous synced origin
    logic [15:0] tmr;
    logic [3:0] bitn;
    logic [9:0] shf;
    logic [3:0] idx; // next expected char
    logic sgn;
    logic [16:0] mag;
    logic [15:0] idle; // cycles since last edge
    logic [35:0] pos;
    logic [35:0] org;
    logic [35:0] mach;
    logic valid;
    logic oset;
    logic err;
    logic zp;
  } aps_host_s;
endpackage : aps_pkg
`default_nettype wire

// *** rtl/aps_link_if.sv ***
// Purpose: the three divided-output lines between drive and host
// Assumes: line drivers are modelled as plain one-way logic
// Notes: no clocking block; the bench joins the ends
`default_nettype none
interface aps_link_if;
  logic phase_a_divided_out; // serial message, then quadrature A
  logic phase_b_divided_out; // quadrature B
  logic origin_pulse_out; // origin pulse, always
  modport dev (output phase_a_divided_out, output phase_b_divided_out,
    output origin_pulse_out);
  modport host (input phase_a_divided_out, input phase_b_divided_out,
    input origin_pulse_out);
endinterface : aps_link_if
`default_nettype wire

// *** rtl/aps_dev.sv ***
// Purpose: drive end, reports absolute position once then runs incrementally
// Assumes: position and steps come from logic on the same clock
// Notes: incremental steps arriving before D_INC are dropped
`default_nettype none
`include "aps_cfg.svh"
module aps_dev
  import aps_pkg::*;
#(
  parameter int unsigned GAP_CYC = `APS_GAP_CYC, // quiet time around the pulse train
  parameter int unsigned BIT_CYC = `APS_BIT_CYC,
  parameter int unsigned EDGE_CYC = `APS_EDGE_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  aps_link_if.dev link,
  input wire logic pos_ready,
  input wire logic [`APS_POS_W-1:0] enc_pos,
  input wire logic [`APS_DIV_W-1:0] position_divider_setting,
  input wire logic direction_select_setting,
  input wire logic inc_step,
  input wire logic inc_up,
  input wire logic origin_mark,
  output logic report_done
);

  aps_dev_s q;
  aps_dev_s d;

  localparam aps_dev_s DEV_RST = '{st: D_WAIT, ph: 2'h1, a: 1'b1, default: '0};

  // decimal weight of digit position, most significant first
  function automatic logic [15:0] wgt(input logic [2:0] i);
    case (i)
      3'h0: wgt = 16'h2710;
      3'h1: wgt = 16'h03E8;
      3'h2: wgt = 16'h0064;
      3'h3: wgt = 16'h000A;
      default: wgt = 16'h0001;
    endcase
  endfunction : wgt

  // character of the message at index c
  function automatic logic [6:0] char_of(input logic [2:0] c, input aps_dev_s s);
    case (c)
      3'h0: char_of = `APS_CH_P;
      3'h1: char_of = s.sgn ? `APS_CH_MINUS : `APS_CH_PLUS; // R14
      3'h7: char_of = `APS_CH_CR;
      default: char_of = `APS_CH_ZERO + {3'h0, s.dig[c - 3'h2]}; // R14
    endcase
  endfunction : char_of

  // next-state logic for the whole sequence
  always_comb begin
    logic [35:0] sp;
    logic [16:0] r;
    logic [35:0] sv;
    logic [6:0] c;
    sp = '0;
    r = '0;
    sv = '0;
    c = '0;
    d = q;
    case (q.st)
      // wait for a valid position; taken once per reset
      D_WAIT: begin
        if (pos_ready) begin
          // reverse direction flips the sign of the reported value
          sp = direction_select_setting ? (36'h0 - enc_pos) : enc_pos;
          d.neg = sp[35]; // R6
          d.num = sp[35] ? (36'h0 - sp) : sp;
          // zero divisor would never finish sensibly, treat as one
          d.dv = (position_divider_setting == 16'h0) ? 16'h1 : position_divider_setting;
          d.rem = '0;
          d.quo = '0;
          d.itr = '0;
          d.st = D_DIV;
        end
      end
      // restoring divide, one quotient bit a cycle, 36 cycles
      D_DIV: begin
        r = {q.rem[15:0], q.num[35]};
        d.num = {q.num[34:0], 1'b0};
        if (r >= {1'b0, q.dv}) begin
          d.rem = r - {1'b0, q.dv}; // R7
          d.quo = {q.quo[34:0], 1'b1};
        end else begin
          d.rem = r;
          d.quo = {q.quo[34:0], 1'b0};
        end
        d.itr = q.itr + 6'h1;
        if (q.itr == 6'd35) begin
          d.st = D_SIGN;
        end
      end
      // restore sign and split into upper and lower parts
      D_SIGN: begin
        sv = q.neg ? (36'h0 - q.quo) : q.quo;
        d.quo = sv;
        d.sgn = sv[35]; // R6
        d.val = sv[35] ? (16'h0 - sv[35:20]) : sv[35:20]; // R1
        d.low = sv[19:0]; // R2
        d.dig = '0;
        d.di = '0;
        d.st = D_BCD;
      end
      // repeated subtraction per digit; at most 9 steps per digit
      D_BCD: begin
        if (q.val >= wgt(q.di)) begin
          d.val = q.val - wgt(q.di);
          d.dig[q.di] = q.dig[q.di] + 4'h1;
        end else if (q.di == 3'h4) begin
          d.chr = '0;
          d.st = D_CHR;
        end else begin
          d.di = q.di + 3'h1;
        end
      end
      // build one frame: stop, even parity, data, start
      D_CHR: begin
        c = char_of(q.chr, q);
        d.shf = {1'b1, ^c, c, 1'b0}; // R3
        d.bitn = '0;
        d.tmr = '0;
        d.st = D_BIT;
      end
      // shift frame out lsb first at the bit rate
      D_BIT: begin
        if (q.tmr == 16'(BIT_CYC - 1)) begin
          d.tmr = '0;
          d.shf = {1'b1, q.shf[9:1]}; // R13
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'(`APS_FRAME_BITS - 1)) begin
            if (q.chr == 3'(`APS_MSG_CHARS - 1)) begin
              d.tmr = '0;
              d.st = D_GAP; // R5
            end else begin
              d.chr = q.chr + 3'h1;
              d.st = D_CHR;
            end
          end
        end else begin
          d.tmr = q.tmr + 16'h1;
        end
      end
      // quiet line between message and pulse train
      D_GAP: begin
        d.tmr = q.tmr + 16'h1;
        if (q.tmr == 16'(GAP_CYC - 1)) begin
          d.tmr = '0;
          d.st = D_TRAIN;
        end
      end
      // lower part as forward quadrature edges
      D_TRAIN: begin
        if (q.low == 20'h0) begin
          d.tmr = '0;
          d.st = D_SETTLE;
        end else if (q.tmr == 16'(EDGE_CYC - 1)) begin
          d.tmr = '0;
          d.ph = q.ph + 2'h1; // R2
          d.low = q.low - 20'h1;
        end else begin
          d.tmr = q.tmr + 16'h1;
        end
      end
      // quiet time lets the host close the count before motion
      D_SETTLE: begin
        d.tmr = q.tmr + 16'h1;
        if (q.tmr == 16'(GAP_CYC - 1)) begin
          d.st = D_INC;
        end
      end
      // incremental running; no way back to the message but reset
      D_INC: begin
        if (inc_step) begin
          d.ph = (inc_up ^ direction_select_setting) ? q.ph + 2'h1 : q.ph - 2'h1; // R11
        end
      end
      default: begin
        d.st = D_WAIT;
      end
    endcase
    // phase A carries the frame while sending, else quadrature
    d.a = (d.st == D_BIT) ? d.shf[0] : (d.ph[1] ^ d.ph[0]); // R1 R11
    d.b = d.ph[1]; // R12
    d.z = origin_mark; // R11
  end

  // single state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= DEV_RST; // R4
    end else begin
      q <= d;
    end
  end

  assign link.phase_a_divided_out = q.a;
  assign link.phase_b_divided_out = q.b;
  assign link.origin_pulse_out = q.z;
  // done flag is a registered decode of the next state; reaching D_INC is final
  always_ff @(posedge clock) begin
    if (!rstn) begin
      report_done <= 1'b0;
    end else begin
      report_done <= (d.st == D_INC); // R4
    end
  end

endmodule : aps_dev
`default_nettype wire

// *** rtl/aps_host.sv ***
// Purpose: host end, receives the message and counts pulses to a position
// Assumes: link lines are foreign and pass two flip-flops first
// Notes: quadrature counted x4; an illegal double step is ignored
`default_nettype none
`include "aps_cfg.svh"
module aps_host
  import aps_pkg::*;
#(
  parameter int unsigned IDLE_CYC = `APS_IDLE_CYC, // must be below the drive gap
  parameter int unsigned BIT_CYC = `APS_BIT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  aps_link_if.host link,
  input wire logic origin_capture,
  output logic [`APS_POS_W-1:0] abs_pos,
  output logic [`APS_POS_W-1:0] mach_pos,
  output logic pos_valid,
  output logic origin_set,
  output logic frame_err,
  output logic origin_seen
);

  aps_host_s q;
  aps_host_s d;

  localparam aps_host_s HOST_RST = '{st: H_HUNT, s1: 3'h1, s2: 3'h1, prv: 2'h1,
    default: '0};

  // gray position of an A,B pair
  function automatic logic [1:0] ph_of(input logic [1:0] ab);
    // B is the high phase bit, so a forward drive step counts up here
    ph_of = {ab[1], ab[1] ^ ab[0]};
  endfunction : ph_of

  // next-state logic
  always_comb begin
    logic [9:0] ns;
    logic [6:0] c;
    logic [15:0] up;
    logic [1:0] dl;
    ns = '0;
    c = '0;
    up = '0;
    dl = '0;
    d = q;
    d.s1 = {link.origin_pulse_out, link.phase_b_divided_out, link.phase_a_divided_out};
    d.s2 = q.s1;
    d.prv = q.s2[1:0];
    d.zprv = q.s2[2];
    d.zp = q.s2[2] & ~q.zprv;
    case (q.st)
      // line idles high; low means a start bit
      H_HUNT: begin
        if (!q.s2[0]) begin
          d.tmr = 16'(BIT_CYC / 2); // R13
          d.bitn = '0;
          d.st = H_BITS;
        end
      end
      // sample each bit mid-cell
      H_BITS: begin
        if (q.tmr == 16'h0) begin
          ns = {q.s2[0], q.shf[9:1]};
          d.shf = ns;
          d.tmr = 16'(BIT_CYC - 1);
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'(`APS_FRAME_BITS - 1)) begin
            c = ns[7:1];
            d.st = H_HUNT;
            if (!ns[9] || (^ns[8:1])) begin
              d.err = 1'b1; // R3
              d.idx = '0;
            end else if (c == `APS_CH_P) begin
              d.idx = 4'h1; // R5
              d.mag = '0;
            end else if (q.idx == 4'h1) begin
              d.sgn = (c == `APS_CH_MINUS);
              d.idx = 4'h2;
            end else if (q.idx >= 4'h2 && q.idx <= 4'h6) begin
              d.mag = 17'((q.mag << 3) + (q.mag << 1) + {10'h0, c - `APS_CH_ZERO});
              d.idx = q.idx + 4'h1;
            end else if (q.idx == 4'h7 && c == `APS_CH_CR) begin
              up = q.sgn ? (16'h0 - q.mag[15:0]) : q.mag[15:0];
              d.pos = {up, 20'h0}; // R8
              d.idle = '0;
              d.st = H_COUNT; // R12
            end else begin
              d.idx = '0;
            end
          end
        end else begin
          d.tmr = q.tmr - 16'h1;
        end
      end
      // counting only after the message ends
      H_COUNT: begin
        dl = ph_of(q.s2[1:0]) - ph_of(q.prv);
        if (dl == 2'h1) begin
          d.pos = q.pos + 36'h1; // R8
          d.idle = '0;
        end else if (dl == 2'h3) begin
          d.pos = q.pos - 36'h1; // R10
          d.idle = '0;
        end else if (q.idle != 16'(IDLE_CYC)) begin
          d.idle = q.idle + 16'h1;
        end else begin
          d.valid = 1'b1; // R2
        end
      end
      default: begin
        d.st = H_HUNT;
      end
    endcase
    if (origin_capture && q.valid && !q.oset) begin
      d.org = q.pos; // R9
      d.oset = 1'b1;
    end
    d.mach = q.pos - q.org; // R8 R10
  end

  // single state register, synchronous reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign abs_pos = q.pos;
  assign mach_pos = q.mach;
  assign pos_valid = q.valid;
  assign origin_set = q.oset;
  assign frame_err = q.err;
  assign origin_seen = q.zp;

endmodule : aps_host
`default_nettype wire

// *** verif/aps_link_properties.sv ***
// Purpose: link-side properties of the position report
// Assumes: one clock, rstn synchronous active low
// Notes: sees only the three link lines, so counts live in helper logic
`default_nettype none
module aps_link_properties #(
  parameter int unsigned BIT_CYC = 2083, // serial bit length
  parameter int unsigned GAP_CYC = 20000 // quiet time before the train
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic phase_a_divided_out,
  input wire logic phase_b_divided_out,
  input wire logic origin_pulse_out
);
  logic a_prev_q; // line a one cycle back
  logic [15:0] run_q; // cycles line a has held
  logic b_seen_q; // train has begun
  logic started_q; // first start bit seen
  logic [5:0] falls_q; // falling edges within the message
  logic a_chg; // line a moved this cycle
  assign a_chg = a_prev_q != phase_a_divided_out;
  // helper state; counters saturate so a long idle cannot wrap
  always_ff @(posedge clock) begin
    if (!rstn) begin
      a_prev_q <= 1'h1;
      run_q <= 16'h0000;
      b_seen_q <= 1'h0;
      started_q <= 1'h0;
      falls_q <= 6'h00;
    end else begin
      a_prev_q <= phase_a_divided_out;
      run_q <= a_chg ? 16'h0001 : (run_q == 16'hFFFF ? run_q : run_q + 16'h0001);
      b_seen_q <= b_seen_q | phase_b_divided_out;
      started_q <= started_q | a_chg;
      if (a_chg && !phase_a_divided_out && !b_seen_q && falls_q != 6'h3F) begin
        falls_q <= falls_q + 6'h01;
      end
    end
  end
  default clocking dflt_cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_RST_IDLE: assert property ($rose(rstn) |-> phase_a_divided_out && !phase_b_divided_out
    && !origin_pulse_out ##1 phase_a_divided_out [*8]) else $error("lines not idle after reset");
  AST_FIRST_START: assert property (a_chg && !started_q |-> !phase_a_divided_out
    && run_q >= 16'h0025) else $error("first start bit early or not low");
  AST_BIT_MIN: assert property (a_chg && started_q && !b_seen_q |-> run_q >= BIT_CYC)
    else $error("serial bit shorter than one bit time");
  AST_LOW_MAX: assert property (a_chg && phase_a_divided_out && !b_seen_q
    |-> run_q <= 9 * BIT_CYC) else $error("serial line low past the stop bit");
  AST_MSG_FALLS: assert property ($rose(phase_b_divided_out) && !b_seen_q
    |-> falls_q >= 6'h08 && falls_q <= 6'h28) else $error("message edge count wrong");
  AST_TRAIN_AFTER_GAP: assert property ($rose(phase_b_divided_out) && !b_seen_q
    |-> phase_a_divided_out && run_q >= GAP_CYC) else $error("train started without gap");
  AST_TRAIN_SPACING: assert property ($rose(phase_b_divided_out) && !b_seen_q
    |=> ($stable(phase_a_divided_out) && $stable(phase_b_divided_out)) [*8])
    else $error("train edges too close");
  AST_QUAD_GRAY: assert property (!($changed(phase_a_divided_out)
    && $changed(phase_b_divided_out))) else $error("both phases moved at once");
endmodule : aps_link_properties
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: joins both ends and checks reported positions and increments
// Assumes: shortened bit, gap and idle counts
// Notes: each row needs its own reset since the message goes once per reset
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [35:0] pos;
    logic [15:0] div;
    logic dir;
    logic [35:0] exp;
  } aps_tb_row_s;
  // lower parts kept small so the pulse trains stay short
  aps_tb_row_s rows [6] = '{
    '{36'h000300005, 16'h0001, 1'h0, 36'h000300005},
    '{36'h001FFFFFD, 16'h0001, 1'h1, 36'hFFE000003},
    '{36'h00140001C, 16'h0004, 1'h0, 36'h000500007},
    '{36'h7FFF00002, 16'h0000, 1'h0, 36'h7FFF00002},
    '{36'h800000001, 16'h0001, 1'h0, 36'h800000001},
    '{36'h00030000B, 16'h0003, 1'h0, 36'h000100003}};
  logic clock, rstn, pos_ready, dir, inc_step, inc_up, origin_mark, origin_capture;
  logic [35:0] enc_pos, abs_pos, mach_pos;
  logic [15:0] divider;
  logic report_done, pos_valid, origin_set, frame_err, origin_seen;
  int errors, checked, cycles;
  localparam int unsigned TB_BIT_CYC = 20; // shortened serial bit
  localparam int unsigned TB_GAP_CYC = 200; // shortened drive gap
  localparam int unsigned TB_IDLE_CYC = 100; // host quiet time, kept below the gap
  aps_link_if link();
  // edge spacing keeps its default so the train spacing check still applies
  aps_dev #(.GAP_CYC(TB_GAP_CYC), .BIT_CYC(TB_BIT_CYC)) i_aps_dev (.clock(clock),
    .rstn(rstn), .link(link), .pos_ready(pos_ready), .enc_pos(enc_pos),
    .position_divider_setting(divider), .direction_select_setting(dir),
    .inc_step(inc_step), .inc_up(inc_up), .origin_mark(origin_mark),
    .report_done(report_done));
  aps_host #(.IDLE_CYC(TB_IDLE_CYC), .BIT_CYC(TB_BIT_CYC)) i_aps_host (.clock(clock),
    .rstn(rstn),
    .link(link), .origin_capture(origin_capture), .abs_pos(abs_pos), .mach_pos(mach_pos),
    .pos_valid(pos_valid), .origin_set(origin_set), .frame_err(frame_err),
    .origin_seen(origin_seen));
  aps_link_properties #(.BIT_CYC(TB_BIT_CYC), .GAP_CYC(TB_GAP_CYC)) i_aps_link_properties (
    .clock(clock),
    .rstn(rstn), .phase_a_divided_out(link.phase_a_divided_out),
    .phase_b_divided_out(link.phase_b_divided_out),
    .origin_pulse_out(link.origin_pulse_out));
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // reset both ends together, looking at idle levels while held
  task automatic do_reset();
    @(posedge clock);
    rstn <= 1'h0;
    pos_ready <= 1'h0;
    repeat (16) @(posedge clock);
    @(negedge clock);
    check("line_a", link.phase_a_divided_out, 36'h1);
    check("line_b", link.phase_b_divided_out, 36'h0);
    check("pos_valid", pos_valid, 36'h0);
    @(posedge clock);
    rstn <= 1'h1;
  endtask : do_reset
  // step pulse during the report must be dropped by the drive
  task automatic start_row(input int r);
    do_reset();
    enc_pos <= rows[r].pos;
    divider <= rows[r].div;
    dir <= rows[r].dir;
    pos_ready <= 1'h1;
    @(posedge clock);
    inc_step <= 1'h1;
    @(posedge clock);
    inc_step <= 1'h0;
  endtask : start_row
  task automatic finish_row(input int r);
    int n;
    n = 0;
    while (report_done !== 1'h1 && n < 6000) begin
      @(posedge clock);
      n++;
    end
    @(negedge clock);
    check("report_done", report_done, 36'h1);
    check("abs_pos", abs_pos, rows[r].exp);
    check("pos_valid", pos_valid, 36'h1);
    check("frame_err", frame_err, 36'h0);
  endtask : finish_row
  task automatic pulse(input logic up, input logic cap);
    @(posedge clock);
    inc_up <= up;
    inc_step <= !cap;
    origin_capture <= cap;
    @(posedge clock);
    inc_step <= 1'h0;
    origin_capture <= 1'h0;
    repeat (6) @(posedge clock);
    @(negedge clock);
  endtask : pulse
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    int n;
    rstn = 1'h0;
    pos_ready = 1'h0;
    dir = 1'h0;
    inc_step = 1'h0;
    inc_up = 1'h0;
    origin_mark = 1'h0;
    origin_capture = 1'h0;
    enc_pos = 36'h0;
    divider = 16'h0001;
    for (int r = 0; r < 6; r++) begin
      start_row(r);
      finish_row(r);
    end
    // a fresh ready after the report must not bring a second message
    pos_ready <= 1'h0;
    enc_pos <= 36'h0;
    @(posedge clock);
    pos_ready <= 1'h1;
    repeat (2000) @(posedge clock);
    @(negedge clock);
    check("abs_late", abs_pos, 36'h000100003);
    pulse(1'h0, 1'h1);
    check("origin_set", origin_set, 36'h1);
    pulse(1'h1, 1'h0);
    pulse(1'h1, 1'h0);
    pulse(1'h1, 1'h0);
    pulse(1'h0, 1'h0);
    check("abs_inc", abs_pos, 36'h000100005);
    check("mach_pos", mach_pos, 36'h000000002);
    pulse(1'h0, 1'h1);
    pulse(1'h1, 1'h0);
    check("mach_kept", mach_pos, 36'h000000003);
    // reverse direction turns an up step into a count down at the host
    @(posedge clock);
    dir <= 1'h1;
    pulse(1'h1, 1'h0);
    check("abs_rev", abs_pos, 36'h000100005);
    check("mach_rev", mach_pos, 36'h000000002);
    @(posedge clock);
    origin_mark <= 1'h1;
    @(posedge clock);
    origin_mark <= 1'h0;
    @(negedge clock);
    check("origin_line", link.origin_pulse_out, 36'h1);
    n = 0;
    while (origin_seen !== 1'h1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check("origin_seen", origin_seen, 36'h1);
    // reset in mid-message, then a whole report must still arrive
    start_row(0);
    repeat (400) @(posedge clock);
    start_row(2);
    finish_row(2);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
